//--- src/iecl_defines.vh
`ifndef IECL_DEFINES_VH
`define IECL_DEFINES_VH

// ==========================================================
// Register byte addresses
`define IECL_OFF_CTRL    8'h00
`define IECL_OFF_SR1     8'h04
`define IECL_OFF_SR2     8'h08
`define IECL_OFF_DATA    8'h0c

// ==========================================================
// Control word fields
`define IECL_CR_PE       5
`define IECL_CR_BROADCAST_CALL_ENABLE     4
`define IECL_CR_START    3
`define IECL_CR_ACK      2
`define IECL_CR_STOP     1
`define IECL_CR_ITE      0

// ==========================================================
// Status one fields
`define IECL_S1_EVF      7
`define IECL_S1_HEADER_SENT_FLAG    6
`define IECL_S1_TRA      5
`define IECL_S1_BUSY     4
`define IECL_S1_BTF      3
`define IECL_S1_HIT      2
`define IECL_S1_MSL      1
`define IECL_S1_SB       0

// ==========================================================
// Status two fields
`define IECL_S2_AF       4
`define IECL_S2_HALT_SEEN_FLAG    3
`define IECL_S2_LOST_ARBITRATION_FLAG     2
`define IECL_S2_MISPLACED_CONDITION_FLAG     1
`define IECL_S2_GCAL     0

// ==========================================================
// Reset values and special data
`define IECL_RST_BYTE    8'h00
`define IECL_BYTE_RELEASE 8'hff
`define IECL_RESP_OKAY   2'h0
`define IECL_RESP_SLVERR 2'h2

`endif

//--- src/iecl_sync.v
`timescale 1ns/1ns

// ==========================================================
// Two-stage synchroniser for the bus pins
module iecl_sync (
   // Clock and reset
   input  wire       clk,
   input  wire       sys_rst,
   // Pins in, synchronised out
   input  wire [1:0] din,
   output wire [1:0] dout
);

   reg [1:0] meta_r;
   reg [1:0] sync_r;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= 2'h3;
         sync_r <= 2'h3;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   assign dout = sync_r;

endmodule

//--- src/iecl_axil.v
`timescale 1ns/1ns
`include "iecl_defines.vh"

// ==========================================================
// AXI4-Lite slave, one write and one read in flight
module iecl_axil (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Write address and data
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // Read address and data
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Register side
   output wire        wrStb,
   output wire [7:0]  wrAddr,
   output wire [7:0]  wrByte,
   output wire        rdStb,
   output wire [7:0]  rdAddr,
   input  wire [7:0]  rdByte
);

   reg       awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   reg       awFull_r, wFull_r, wLane_r, rdPend_r;
   reg [1:0] bresp_r, rresp_r;
   reg [7:0] awAddr_r, wByte_r, arAddr_r, rdata_r;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `IECL_OFF_CTRL) | (a == `IECL_OFF_SR1) |
                  (a == `IECL_OFF_SR2) | (a == `IECL_OFF_DATA);
      end
   endfunction

   wire issue = awFull_r & wFull_r & ~bvalid_r;
   assign wrStb  = issue & wLane_r & mapped(awAddr_r);
   assign wrAddr = awAddr_r;
   assign wrByte = wByte_r;
   assign rdStb  = rdPend_r & ~rvalid_r & mapped(arAddr_r);
   assign rdAddr = arAddr_r;

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         arready_r <= 1'b1;
         bvalid_r  <= 1'b0;
         rvalid_r  <= 1'b0;
         awFull_r  <= 1'b0;
         wFull_r   <= 1'b0;
         wLane_r   <= 1'b0;
         rdPend_r  <= 1'b0;
         bresp_r   <= `IECL_RESP_OKAY;
         rresp_r   <= `IECL_RESP_OKAY;
         awAddr_r  <= 8'h00;
         wByte_r   <= 8'h00;
         arAddr_r  <= 8'h00;
         rdata_r   <= 8'h00;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awAddr_r  <= s_axi_awaddr;
            awFull_r  <= 1'b1;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            wByte_r  <= s_axi_wdata[7:0];
            wLane_r  <= s_axi_wstrb[0];
            wFull_r  <= 1'b1;
            wready_r <= 1'b0;
         end
         if (issue) begin
            bvalid_r <= 1'b1;
            bresp_r  <= mapped(awAddr_r) ? `IECL_RESP_OKAY : `IECL_RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awFull_r  <= 1'b0;
            wFull_r   <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
         if (s_axi_arvalid && arready_r) begin
            arAddr_r  <= s_axi_araddr;
            rdPend_r  <= 1'b1;
            arready_r <= 1'b0;
         end
         if (rdPend_r && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= mapped(arAddr_r) ? rdByte : 8'h00;
            rresp_r  <= mapped(arAddr_r) ? `IECL_RESP_OKAY : `IECL_RESP_SLVERR;
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            rdPend_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = {24'h000000, rdata_r};

endmodule

//--- src/iecl_core.v
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "iecl_defines.vh"


module iecl_core (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // AXI4-Lite register port
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   // Serial bus pins
   input  wire        sclIn,
   output wire        sclOut,
   output wire        sclOeN,
   input  wire        sdaIn,
   output wire        sdaOut,
   output wire        sdaOeN,
   // Datapath event pulses
   input  wire        evAddrHit,
   input  wire        evGenCall,
   input  wire        evByteRx,
   input  wire        evByteTx,
   input  wire        evNack,
   input  wire        evStartSent,
   input  wire        evHeaderSent,
   input  wire        evAddrSent,
   input  wire        evArbLost,
   input  wire        evBusErr,
   input  wire        evStopSent,
   input  wire        sdaLowReq,
   input  wire [7:0]  rxByte,
   // Datapath controls
   output wire [7:0]  txByte,
   output wire        pinAltSel,
   output wire        ackOut,
   output wire        startReq,
   output wire        stopReq,
   output wire        bcastOut,
   output wire        masterOut,
   // Processor side
   input  wire        cpuIntMask,
   input  wire        cpuHalt,
   output wire        irq
);

   // ==========================================================
   // Register port and pin synchroniser
   wire       wrStb, rdStb;
   wire [7:0] wrAddr, wrByte, rdAddr;
   reg  [7:0] rdByte;
   wire [1:0] pinS;

   iecl_axil uAxil (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wrStb         (wrStb),
      .wrAddr        (wrAddr),
      .wrByte        (wrByte),
      .rdStb         (rdStb),
      .rdAddr        (rdAddr),
      .rdByte        (rdByte)
   );

   iecl_sync uSync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({sclIn, sdaIn}),
      .dout    (pinS)
   );

   // ==========================================================
   // State
   reg       unitOn_r, bcastEn_r, startBit_r, ackEn_r, stopBit_r, irqEn_r;
   reg       hdr_r, dir_r, busy_r, btf_r, hit_r, master_r, sb_r, addrDone_r;
   reg       nack_r, stopSeen_r, arb_r, misplaced_condition_flag_r, gcal_r;
   reg       armed_r, supp_r, relArm_r, sdaPrev_r;
   reg [7:0] dataByte_r;
   reg       sclOeN_r, sdaOeN_r, irq_r, ackOut_r, startReq_r, stopReq_r, pinAlt_r;

   // ==========================================================
   // Decode and events
   // halt freeze
   wire live     = unitOn_r & ~cpuHalt;
   wire sclS     = pinS[1];
   wire sdaS     = pinS[0];
   wire startDet = live & sclS & sdaPrev_r & ~sdaS;
   wire stopDet  = live & sclS & ~sdaPrev_r & sdaS;

   wire wrCtrl = wrStb & (wrAddr == `IECL_OFF_CTRL);
   wire wrBuf  = wrStb & (wrAddr == `IECL_OFF_DATA);
   wire rdSr1  = rdStb & (rdAddr == `IECL_OFF_SR1);
   wire rdSr2  = rdStb & (rdAddr == `IECL_OFF_SR2);
   wire rdBuf  = rdStb & (rdAddr == `IECL_OFF_DATA);

   wire fullWr   = wrCtrl & unitOn_r & wrByte[`IECL_CR_PE];
   wire stopFall = fullWr & stopBit_r & ~wrByte[`IECL_CR_STOP];

   wire eGc  = live & evGenCall & bcastEn_r;
   wire eHit = (live & evAddrHit) | eGc;
   wire eTx  = live & evByteTx & ~gcal_r;
   wire eRx  = live & evByteRx;

   wire event_pending = btf_r | hit_r | sb_r | nack_r | stopSeen_r | arb_r | misplaced_condition_flag_r |
              hdr_r | addrDone_r;

   always @* begin
      rdByte = 8'h00;
      case (rdAddr)
         `IECL_OFF_CTRL: rdByte = {2'b00, unitOn_r, bcastEn_r, startBit_r,
                                   ackEn_r, stopBit_r, irqEn_r};
         `IECL_OFF_SR1:  rdByte = {event_pending, hdr_r, dir_r, busy_r, btf_r, hit_r,
                                   master_r, sb_r};
         `IECL_OFF_SR2:  rdByte = {3'b000, nack_r, stopSeen_r, arb_r, misplaced_condition_flag_r,
                                   gcal_r};
         `IECL_OFF_DATA: rdByte = dataByte_r;
         default:        rdByte = 8'h00;
      endcase
   end

   // ==========================================================
   // Control and status flags; later assignments win, so datapath events beat software writes and clears
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         unitOn_r   <= 1'b0;
         bcastEn_r  <= 1'b0;
         startBit_r <= 1'b0;
         ackEn_r    <= 1'b0;
         stopBit_r  <= 1'b0;
         irqEn_r    <= 1'b0;
         hdr_r      <= 1'b0;
         dir_r      <= 1'b0;
         busy_r     <= 1'b0;
         btf_r      <= 1'b0;
         hit_r      <= 1'b0;
         master_r   <= 1'b0;
         sb_r       <= 1'b0;
         addrDone_r <= 1'b0;
         nack_r     <= 1'b0;
         stopSeen_r <= 1'b0;
         arb_r      <= 1'b0;
         misplaced_condition_flag_r     <= 1'b0;
         gcal_r     <= 1'b0;
         armed_r    <= 1'b0;
         supp_r     <= 1'b0;
         relArm_r   <= 1'b0;
         sdaPrev_r  <= 1'b1;
         dataByte_r <= `IECL_RST_BYTE;
      end else begin
         sdaPrev_r <= sdaS;
         // Software writes
         if (wrCtrl) begin
            unitOn_r <= wrByte[`IECL_CR_PE];
         end
         if (fullWr) begin
            bcastEn_r  <= wrByte[`IECL_CR_BROADCAST_CALL_ENABLE];
            startBit_r <= wrByte[`IECL_CR_START];
            ackEn_r    <= wrByte[`IECL_CR_ACK];
            stopBit_r  <= wrByte[`IECL_CR_STOP];
            irqEn_r    <= wrByte[`IECL_CR_ITE];
         end
         if (fullWr && wrByte[`IECL_CR_START]) begin
            master_r <= 1'b1;
         end
         if (wrBuf) begin
            dataByte_r <= wrByte;
         end
         // Software clear sequences
         // hit clear
         if (rdSr1) begin
            hit_r   <= 1'b0;
            armed_r <= 1'b1;
         end
         if (rdSr1 || rdSr2) begin
            nack_r <= 1'b0;
         end
         if (rdSr2) begin
            stopSeen_r <= 1'b0;
            arb_r      <= 1'b0;
            misplaced_condition_flag_r     <= 1'b0;
         end
         if (rdBuf && armed_r) begin
            if (!dir_r) begin
               btf_r <= 1'b0;
            end
            armed_r <= 1'b0;
         end
         if (wrBuf && armed_r) begin
            if (dir_r) begin
               btf_r <= 1'b0;
               dir_r <= 1'b0;
            end
            sb_r    <= 1'b0;
            hdr_r   <= 1'b0;
            armed_r <= 1'b0;
         end
         if (wrCtrl && armed_r) begin
            addrDone_r <= 1'b0;
            armed_r    <= 1'b0;
         end
         if (wrBuf && wrByte == `IECL_BYTE_RELEASE && btf_r) begin
            btf_r <= 1'b0;
            dir_r <= 1'b0;
         end
         if (stopFall && btf_r) begin
            btf_r  <= 1'b0;
            dir_r  <= 1'b0;
            supp_r <= 1'b1;
         end
         if (stopBit_r && !master_r && btf_r) begin
            relArm_r <= 1'b1;
         end
         // Bus conditions
         if (startDet) begin
            busy_r   <= 1'b1;
            relArm_r <= 1'b0;
         end
         if (stopDet) begin
            busy_r   <= 1'b0;
            gcal_r   <= 1'b0;
            dir_r    <= 1'b0;
            master_r <= 1'b0;
            supp_r   <= 1'b0;
            if (!master_r && !supp_r && ackEn_r) begin
               stopSeen_r <= 1'b1;
            end
         end
         // Datapath events
         if (eHit) begin
            hit_r <= 1'b1;
         end
         if (eGc) begin
            gcal_r <= 1'b1;
         end
         if (eRx) begin
            btf_r      <= 1'b1;
            dir_r      <= 1'b0;
            dataByte_r <= rxByte;
         end
         if (eTx) begin
            btf_r <= 1'b1;
            dir_r <= 1'b1;
         end
         if (live && evNack) begin
            nack_r <= 1'b1;
         end
         if (live && evStartSent) begin
            startBit_r <= 1'b0;
            sb_r       <= 1'b1;
         end
         if (live && evHeaderSent) begin
            hdr_r <= 1'b1;
         end
         if (live && evAddrSent) begin
            addrDone_r <= 1'b1;
         end
         if (live && evStopSent && master_r) begin
            stopBit_r <= 1'b0;
         end
         if (live && evArbLost) begin
            arb_r    <= 1'b1;
            master_r <= 1'b0;
            dir_r    <= 1'b0;
         end
         if (live && evBusErr) begin
            misplaced_condition_flag_r <= 1'b1;
            busy_r <= 1'b0;
         end
         if (!unitOn_r) begin
            bcastEn_r  <= 1'b0;
            startBit_r <= 1'b0;
            ackEn_r    <= 1'b0;
            irqEn_r    <= 1'b0;
            hdr_r      <= 1'b0;
            dir_r      <= 1'b0;
            busy_r     <= 1'b0;
            btf_r      <= 1'b0;
            hit_r      <= 1'b0;
            master_r   <= 1'b0;
            sb_r       <= 1'b0;
            addrDone_r <= 1'b0;
            nack_r     <= 1'b0;
            stopSeen_r <= 1'b0;
            arb_r      <= 1'b0;
            misplaced_condition_flag_r     <= 1'b0;
            gcal_r     <= 1'b0;
            armed_r    <= 1'b0;
            supp_r     <= 1'b0;
            relArm_r   <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Registered outputs
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclOeN_r   <= 1'b1;
         sdaOeN_r   <= 1'b1;
         irq_r      <= 1'b0;
         ackOut_r   <= 1'b0;
         startReq_r <= 1'b0;
         stopReq_r  <= 1'b0;
         pinAlt_r   <= 1'b0;
      end else begin
         sclOeN_r <= ~(live & ~relArm_r &
                       (hdr_r | sb_r | btf_r | hit_r | addrDone_r));
         sdaOeN_r <= ~(live & ~relArm_r & sdaLowReq);
         irq_r <= irqEn_r & ~cpuIntMask & ~cpuHalt & event_pending;
         ackOut_r <= ackEn_r & live;
         startReq_r <= startBit_r & live & (master_r | ~busy_r);
         stopReq_r  <= stopBit_r & master_r & live;
         pinAlt_r   <= unitOn_r;
      end
   end

   // Pins only ever pull low; the enables decide
   assign sclOut    = 1'b0;
   assign sdaOut    = 1'b0;
   assign sclOeN    = sclOeN_r;
   assign sdaOeN    = sdaOeN_r;
   assign irq       = irq_r;
   assign ackOut    = ackOut_r;
   assign startReq  = startReq_r;
   assign stopReq   = stopReq_r;
   assign pinAltSel = pinAlt_r;
   assign bcastOut  = bcastEn_r;
   assign masterOut = master_r;
   assign txByte    = dataByte_r;

endmodule

//--- test/iecl_core_asserts.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker
module iecl_core_asserts (
   // Clock and reset
   input logic        clk,
   input logic        sys_rst,
   // Read channel
   input logic [7:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   // Pins and datapath
   input logic        sclOeN,
   input logic        evByteRx,
   input logic        pinAltSel,
   input logic        startReq,
   input logic        stopReq,
   input logic        bcastOut,
   input logic        masterOut,
   input logic        ackOut,
   // Processor
   input logic        cpuIntMask,
   input logic        cpuHalt,
   input logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Properties
   irq_gated_a: assert property ((cpuHalt || cpuIntMask) |=> !irq)
      else $error("irq while gated");
   halt_no_ack_a: assert property (cpuHalt |=> !ackOut)
      else $error("ack enabled in halt");
   rx_holds_scl_a: assert property (evByteRx && pinAltSel && !cpuHalt |-> ##2 !sclOeN)
      else $error("clock line not held");
   off_clears_a: assert property ($fell(pinAltSel) |=>
      !bcastOut && !masterOut && !startReq && !ackOut) else $error("disable left bits");
   off_release_a: assert property (!pinAltSel && !$past(pinAltSel) |-> sclOeN)
      else $error("line driven while off");
   stop_master_a: assert property (stopReq |-> $past(masterOut))
      else $error("stop outside master");
   rst_idle_a: assert property ($fell(sys_rst) |-> sclOeN && !irq && s_axi_arready)
      else $error("not idle after reset");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c
      |-> ##2 s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("bad read");
   cover property ($rose(irq));
   cover property ($fell(sclOeN));
   cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind iecl_core iecl_core_asserts chk (.*);

//--- test/iecl_bus_peer.sv
`timescale 1ns/1ns
// ==========================================================
// Far-side bus party, open drain with pull-ups
module iecl_bus_peer (
   // Design enables
   input  logic sclOeN,
   input  logic sdaOeN,
   // Resolved lines
   output logic sclIn,
   output logic sdaIn
);
   logic sclHi = 1'b1;
   logic sdaHi = 1'b1;
   assign sclIn = sclHi & sclOeN;
   assign sdaIn = sdaHi & sdaOeN;
   // Clock idles high outside the frame
   task frame();
      begin
         // Keep pin changes off the clock edge
         #5;
         sdaHi = 1'b0;
         #80;
         repeat (2) begin
            sclHi = 1'b0;
            #80;
            sclHi = 1'b1;
            #80;
         end
         sdaHi = 1'b1;
         #160;
      end
   endtask
endmodule

//--- test/iecl_core_test.sv
`timescale 1ns/1ns
// ==========================================================
// Register-level bench
module iecl_core_test;
   logic        clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sdaLowReq;
   logic        s_axi_bready, s_axi_rready, cpuIntMask, cpuHalt;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rxByte;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic [10:0] ev;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [7:0]  txByte;
   wire         sclIn, sclOut, sclOeN, sdaIn, sdaOut, sdaOeN, irq, pinAltSel, ackOut;
   wire         startReq, stopReq, bcastOut, masterOut, evAddrHit, evGenCall, evByteRx;
   wire         evByteTx, evNack, evStartSent, evHeaderSent, evAddrSent, evArbLost;
   wire         evBusErr, evStopSent;
   integer      errors, total_checks;
   assign {evStopSent, evBusErr, evArbLost, evAddrSent, evHeaderSent, evStartSent,
           evNack, evByteTx, evByteRx, evGenCall, evAddrHit} = ev;
   iecl_core uut (.*);
   iecl_bus_peer peer (.sclOeN(sclOeN), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));
   // ==========================================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid);
         chk(s_axi_bresp, er);
      end
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         chk(s_axi_rdata, exp);
         chk(s_axi_rresp, (a > 8'h0c) ? 2'h2 : 2'h0);
      end
   endtask
   task fire(input integer i);
      begin
         ev[i] <= 1'b1;
         @(posedge clk);
         ev <= '0;
         repeat (2) @(posedge clk);
      end
   endtask
   task stop_test();
      begin
         $display("Checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // ==========================================================
   // Stimulus
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      errors = errors + 1;
      stop_test();
   end
   initial begin
      errors = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cpuIntMask, cpuHalt, sdaLowReq} = '0;
      {s_axi_awaddr, s_axi_araddr, rxByte, ev, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      {s_axi_bready, s_axi_rready} = 2'b11;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rc(8'h00, 32'h00);
      wc(8'h00, 8'hf5, 2'h0);
      rc(8'h00, 32'h20);
      wc(8'h00, 8'hf5, 2'h0);
      rc(8'h00, 32'h35);
      chk(ackOut, 32'h1);
      rxByte <= 8'ha5;
      fire(2);
      chk(irq, 32'h1);
      chk(sclOeN, 32'h0);
      rc(8'h04, 32'h88);
      rc(8'h04, 32'h88);
      rc(8'h0c, 32'ha5);
      rc(8'h04, 32'h00);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      chk(sclOeN, 32'h1);
      fire(3);
      rc(8'h04, 32'ha8);
      wc(8'h0c, 8'h3c, 2'h0);
      rc(8'h04, 32'h00);
      chk(txByte, 32'h3c);
      cpuIntMask <= 1'b1;
      fire(0);
      chk(irq, 32'h0);
      rc(8'h04, 32'h84);
      rc(8'h04, 32'h00);
      cpuIntMask <= 1'b0;
      cpuHalt <= 1'b1;
      fire(2);
      chk(ackOut, 32'h0);
      rc(8'h04, 32'h00);
      cpuHalt <= 1'b0;
      fire(1);
      fire(3);
      rc(8'h04, 32'h84);
      rc(8'h08, 32'h01);
      peer.frame();
      repeat (6) @(posedge clk);
      rc(8'h08, 32'h08);
      rc(8'h04, 32'h00);
      fire(3);
      fire(4);
      rc(8'h04, 32'ha8);
      rc(8'h08, 32'h00);
      wc(8'h00, 8'h37, 2'h0);
      repeat (2) @(posedge clk);
      chk(sclOeN, 32'h1);
      wc(8'h00, 8'h35, 2'h0);
      @(posedge clk);
      chk(irq, 32'h0);
      fire(3);
      wc(8'h0c, 8'hff, 2'h0);
      rc(8'h04, 32'h00);
      peer.frame();
      repeat (6) @(posedge clk);
      rc(8'h08, 32'h00);
      wc(8'h00, 8'h3d, 2'h0);
      repeat (2) @(posedge clk);
      chk(masterOut, 32'h1);
      fire(5);
      rc(8'h00, 32'h35);
      rc(8'h04, 32'h83);
      wc(8'h0c, 8'ha0, 2'h0);
      rc(8'h04, 32'h02);
      fire(6);
      rc(8'h04, 32'hc2);
      wc(8'h0c, 8'h11, 2'h0);
      rc(8'h04, 32'h02);
      chk(txByte, 32'h11);
      fire(7);
      chk(sclOeN, 32'h0);
      rc(8'h04, 32'h82);
      wc(8'h00, 8'h35, 2'h0);
      rc(8'h04, 32'h02);
      wc(8'h10, 8'h01, 2'h2);
      rc(8'h10, 32'h00);
      wc(8'h00, 8'h37, 2'h0);
      repeat (2) @(posedge clk);
      chk(stopReq, 32'h1);
      fire(10);
      rc(8'h00, 32'h35);
      wc(8'h00, 8'h37, 2'h0);
      sdaLowReq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(sdaOeN, 32'h0);
      wc(8'h00, 8'h02, 2'h0);
      repeat (2) @(posedge clk);
      rc(8'h00, 32'h02);
      chk(bcastOut, 32'h0);
      chk(masterOut, 32'h0);
      chk(sdaOeN, 32'h1);
      chk(pinAltSel, 32'h0);
      sdaLowReq <= 1'b0;
      stop_test();
   end
endmodule
